// >>> smb_dev.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Write byte: address, command, data, all acknowledged
// - Controller sets pointer before block write
// - Block write length equals programmed length
// - Command 0xA0 opens a block write
// - Acknowledge every block write data byte
// - Check PEC; nack on mismatch, controller resends; device checks it only after a block write
// - Receive byte returns pointed register, then nack
// - Block read at most 32 bytes
// - 0xA1 then repeated start and read address
// - First block read byte is the count
// - Data then PEC, controller nacks and stops
// - Controller checks read PEC, repeats on failure
// - PEC optional; transfers work without it
// - PEC is CRC-8, poly x^8+x^2+x+1
// - Answer alert address with own address
// - Arbitrate while sending address on alert
// - Alert released only when condition clears
// - Idle-low timeout abandons transfer, frees lines
// - Config 3 bit 1 enables clock timeout
// - Config 3 bit 2 enables data timeout
// - Send byte loads the address pointer
module smb_dev
   import smb_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h58,       // Own bus address
   parameter int         TO_CYC   = TIMEOUT_CYC  // Bus lock timeout in cycles
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   smb_if.dev               pins,
   input  wire logic        alert_req,
   input  wire logic [7:0]  usr_rdata,
   output logic             usr_we,
   output logic [7:0]       usr_waddr,
   output logic [7:0]       usr_wdata,
   output logic [7:0]       usr_raddr
);
   localparam int TOW = $clog2(TO_CYC + 1);

   if (TO_CYC < 1) begin : g_bad_to
      $error("TO_CYC must be at least one");
   end

   typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_RACK, S_SKIP} smb_st_e;
   typedef enum logic [2:0] {K_ARA, K_CNT, K_DAT, K_SGL, K_PEC, K_END} smb_txk_e;

   typedef struct packed {
      logic           scl1, scl2, sda1, sda2;  // Pin synchronisers
      logic           scl_q, sda_q;            // Previous synced levels
      smb_st_e        st;                      // Byte level state
      smb_txk_e       txk;                     // What the next sent byte is
      logic [3:0]     nb;                      // Bit count in byte
      logic [7:0]     sh;                      // Receive shifter
      logic [7:0]     tx;                      // Transmit shifter
      logic [7:0]     ptr;                     // Address pointer
      logic [7:0]     cfg0, cfg3;              // Local configuration
      logic [7:0]     crc;                     // Running packet check
      logic [5:0]     left;                    // Block bytes remaining
      logic [1:0]     bi;                      // Write byte index
      logic           first, blkw, pend, mack; // Sequence flags
      logic           sda_oe, alert, we;
      logic [7:0]     wa, wd;
      logic [TOW-1:0] to;                      // Timeout counter
   } smb_dev_s;

   smb_dev_s r, n;

   // Next state of the whole device
   always_comb begin
      logic       rise, fall, sta, sto;
      logic [5:0] len;
      logic [7:0] rdv, v;
      rise = 1'b0;
      fall = 1'b0;
      sta  = 1'b0;
      sto  = 1'b0;
      len  = 6'h00;
      rdv  = 8'h00;
      v    = 8'h00;
      n      = r;
      n.we   = 1'b0;
      // Two flip-flops before any logic reads a pin
      n.scl1  = pins.scl;
      n.scl2  = r.scl1;
      n.sda1  = pins.sda;
      n.sda2  = r.sda1;
      n.scl_q = r.scl2;
      n.sda_q = r.sda2;
      n.alert = alert_req;
      rise = r.scl2 & ~r.scl_q;
      fall = ~r.scl2 & r.scl_q;
      sta  = r.scl2 & r.scl_q & r.sda_q & ~r.sda2;
      sto  = r.scl2 & r.scl_q & ~r.sda_q & r.sda2;
      // Length field clamped to the block maximum
      len = r.cfg0[LEN_LSB +: LEN_W];
      if (len > BLK_MAX) begin
         len = BLK_MAX;
      end
      // Read source for the pointed register
      if (r.ptr == CFG0_OFS) begin
         rdv = r.cfg0;
      end else if (r.ptr == CFG3_OFS) begin
         rdv = r.cfg3;
      end else begin
         rdv = usr_rdata;
      end
      // Low-line timer, only while a transfer is open
      if (r.st != S_IDLE &&
          ((r.cfg3[CFG3_SCL_TO] & ~r.scl2) | (r.cfg3[CFG3_SDA_TO] & ~r.sda2))) begin
         n.to = r.to + TOW'(1);
      end else begin
         n.to = '0;
      end
      // Byte to send next, chosen by the current kind
      unique case (r.txk)
         K_ARA: v = {DEV_ADDR, 1'b0};
         K_CNT: v = {2'b00, len};
         K_DAT: v = rdv;
         K_SGL: v = rdv;
         K_PEC: v = r.crc;
         K_END: v = 8'hFF;
      endcase

      unique case (r.st)
         S_IDLE, S_SKIP: begin
            // Wait for a start
         end
         S_RX: begin
            if (rise) begin
               n.sh = {r.sh[6:0], r.sda2};
               n.nb = r.nb + 4'h1;
            end
            if (fall && r.nb == 4'h8) begin
               n.st     = S_ACK;
               n.sda_oe = 1'b1;
               n.crc    = smb_crc8(r.crc, r.sh);
               if (r.first) begin
                  // Address byte
                  n.first = 1'b0;
                  n.bi    = 2'h0;
                  if (r.sh[0] && r.sh[7:1] == ARA_ADDR && r.alert) begin
                     n.txk = K_ARA;
                  end else if (r.sh[7:1] == DEV_ADDR) begin
                     n.txk = r.pend ? K_CNT : K_SGL;
                  end else begin
                     n.st     = S_SKIP;
                     n.sda_oe = 1'b0;
                  end
                  n.mack = r.sh[0];  // Remember direction until the ack ends
               end else if (r.bi == 2'h0) begin
                  // Command byte
                  n.bi = 2'h1;
                  if (r.sh == CMD_BLK_WR) begin
                     n.blkw = 1'b1;
                     n.left = len;
                  end else if (r.sh == CMD_BLK_RD) begin
                     n.pend = 1'b1;
                  end else begin
                     n.ptr = r.sh;
                  end
               end else if (r.blkw && r.left == 6'h00) begin
                  // Check byte after the block
                  n.crc    = r.crc;
                  n.blkw   = 1'b0;
                  n.sda_oe = (r.crc == r.sh);
               end else if (r.blkw || r.bi == 2'h1) begin
                  // Data byte into the pointed register
                  n.bi = 2'h2;
                  if (r.ptr == CFG0_OFS) begin
                     n.cfg0 = r.sh;
                  end else if (r.ptr == CFG3_OFS) begin
                     n.cfg3 = r.sh;
                  end else begin
                     n.we = 1'b1;
                     n.wa = r.ptr;
                     n.wd = r.sh;
                  end
                  if (r.blkw) begin
                     n.ptr  = r.ptr + 8'h01;
                     n.left = r.left - 6'h01;
                  end
               end
            end
         end
         S_ACK: begin
            if (fall) begin
               n.sda_oe = 1'b0;
               n.nb     = 4'h0;
               n.st     = S_RX;
               if (r.mack && !r.first) begin
                  // Read: drive first bit on this same falling edge
                  n.st     = S_TX;
                  n.sda_oe = ~v[7];
                  n.tx     = {v[6:0], 1'b1};
                  n.nb     = 4'h1;
                  n.crc    = smb_crc8(r.crc, v);
                  if (r.txk == K_CNT) begin
                     n.left = len;
                     n.txk  = (len == 6'h00) ? K_PEC : K_DAT;
                  end else begin
                     n.txk = K_END;
                  end
               end
            end
         end
         S_TX: begin
            // Lost arbitration: a released one read back as low
            if (rise && !r.sda_oe && !r.sda2) begin
               n.st = S_SKIP;
            end
            if (fall) begin
               if (r.nb == 4'h8) begin
                  n.sda_oe = 1'b0;
                  n.st     = S_RACK;
               end else begin
                  n.sda_oe = ~r.tx[7];
                  n.tx     = {r.tx[6:0], 1'b1};
                  n.nb     = r.nb + 4'h1;
               end
            end
         end
         S_RACK: begin
            if (rise) begin
               n.mack = ~r.sda2;
            end
            if (fall) begin
               if (r.mack && r.txk != K_END) begin
                  // Controller acked: next byte
                  n.st     = S_TX;
                  n.sda_oe = ~v[7];
                  n.tx     = {v[6:0], 1'b1};
                  n.nb     = 4'h1;
                  if (r.txk == K_PEC) begin
                     n.txk = K_END;
                  end else begin
                     n.crc  = smb_crc8(r.crc, v);
                     n.ptr  = r.ptr + 8'h01;
                     n.left = r.left - 6'h01;
                     n.txk  = (r.left == 6'h01) ? K_PEC : K_DAT;
                  end
               end else begin
                  n.st = S_SKIP;
               end
            end
         end
      endcase

      // Start or repeated start: next byte is an address
      if (sta) begin
         n.st     = S_RX;
         n.nb     = 4'h0;
         n.first  = 1'b1;
         n.mack   = 1'b0;
         n.sda_oe = 1'b0;
      end
      // Stop or timeout closes the transfer and frees the line
      if (sto || r.to == TOW'(TO_CYC)) begin
         n.st     = S_IDLE;
         n.sda_oe = 1'b0;
         n.crc    = 8'h00;
         n.pend   = 1'b0;
         n.blkw   = 1'b0;
         n.to     = '0;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r      <= '0;
         r.scl1 <= 1'b1;
         r.scl2 <= 1'b1;
         r.sda1 <= 1'b1;
         r.sda2 <= 1'b1;
         r.scl_q <= 1'b1;
         r.sda_q <= 1'b1;
         r.st   <= S_IDLE;
         r.txk  <= K_END;
         r.cfg0 <= CFG0_RST;
         r.cfg3 <= CFG3_RST;
      end else begin
         r <= n;
      end
   end

   // Pins and user side
   assign pins.s_sda_o   = 1'b0;
   assign pins.s_sda_oe  = r.sda_oe;
   assign pins.s_alrt_o  = 1'b0;
   assign pins.s_alrt_oe = r.alert;
   assign usr_we         = r.we;
   assign usr_waddr      = r.wa;
   assign usr_wdata      = r.wd;
   assign usr_raddr      = r.ptr;
endmodule : smb_dev

// >>> smb_pkg.sv
// Shared constants and helpers for both ends of the management bus link
package smb_pkg;
   // Command codes
   localparam logic [7:0] CMD_BLK_WR   = 8'hA0;  // Block write command
   localparam logic [7:0] CMD_BLK_RD   = 8'hA1;  // Block read command
   localparam logic [6:0] ARA_ADDR     = 7'h0C;  // Alert response address
   // Device registers held locally
   localparam logic [7:0] CFG0_OFS     = 8'h00;  // Block length register
   localparam logic [7:0] CFG3_OFS     = 8'h03;  // bus_timeout_config
   localparam logic [7:0] CFG0_RST     = 8'h00;
   localparam logic [7:0] CFG3_RST     = 8'h00;
   localparam int         CFG3_SCL_TO  = 1;      // Clock-line timeout enable
   localparam int         CFG3_SDA_TO  = 2;      // Data-line timeout enable
   localparam int         LEN_LSB      = 0;      // Block length field
   localparam int         LEN_W        = 6;
   localparam logic [5:0] BLK_MAX      = 6'h20;  // At most 32 bytes
   localparam logic [7:0] CRC_POLY     = 8'h07;  // x^8 + x^2 + x + 1
   // Timing
   localparam int         CLK_NS       = 5;
   localparam int         TIMEOUT_MS   = 25;
   localparam int         TIMEOUT_CYC  = TIMEOUT_MS * 1000000 / CLK_NS;
   localparam int         SCL_HALF_NS  = 5000;
   localparam int         SCL_HALF_CYC = SCL_HALF_NS / CLK_NS;
   // Controller APB map and fields
   localparam logic [7:0] HREG_CMD     = 8'h00;
   localparam logic [7:0] HREG_STAT    = 8'h04;
   localparam int         CMD_OP_LSB   = 0;
   localparam int         CMD_NACK     = 3;
   localparam int         CMD_DAT_LSB  = 8;
   localparam int         ST_BUSY      = 0;
   localparam int         ST_ACK       = 1;
   localparam int         ST_ALERT     = 2;
   localparam int         ST_RX_LSB    = 8;
   localparam int         ST_CRC_LSB   = 16;
   localparam logic [2:0] OP_START     = 3'h1;
   localparam logic [2:0] OP_STOP      = 3'h2;
   localparam logic [2:0] OP_WR        = 3'h3;
   localparam logic [2:0] OP_RD        = 3'h4;

   // One byte folded into the running check value
   function automatic logic [7:0] smb_crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] x;
      x = c ^ d;
      for (int i = 0; i < 8; i++) begin
         x = x[7] ? ((x << 1) ^ CRC_POLY) : (x << 1);
      end
      return x;
   endfunction : smb_crc8
endpackage : smb_pkg

// >>> smb_if.sv
`timescale 1ns/1ps
// Open-drain bus wires; a line is low while any end enables its driver
interface smb_if;
   logic m_scl_o;    // Controller clock drive value
   logic m_scl_oe;   // Controller clock enable
   logic m_sda_o;    // Controller data drive value
   logic m_sda_oe;   // Controller data enable
   logic s_sda_o;    // Device data drive value
   logic s_sda_oe;   // Device data enable
   logic s_alrt_o;   // Device alert drive value
   logic s_alrt_oe;  // Device alert enable
   logic scl;        // Resolved clock line
   logic sda;        // Resolved data line
   logic alert_n;    // Resolved alert line
   // Pull-ups win unless an enabled driver pulls low
   assign scl     = ~(m_scl_oe & ~m_scl_o);
   assign sda     = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));
   assign alert_n = ~(s_alrt_oe & ~s_alrt_o);
   modport dev  (input scl, sda, output s_sda_o, s_sda_oe, s_alrt_o, s_alrt_oe);
   modport host (input scl, sda, alert_n, output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe);
endinterface : smb_if

// >>> smb_host.sv
`timescale 1ns/1ps
// Bus controller: software sequences start, stop and byte operations
module smb_host
   import smb_pkg::*;
#(
   parameter int HALF_CYC = SCL_HALF_CYC  // Half clock period in cycles
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   smb_if.host              pins,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr
);
   if (HALF_CYC < 4 || HALF_CYC > 65535) begin : g_bad_half
      $error("HALF_CYC out of range");
   end

   typedef enum logic [1:0] {H_IDLE, H_START, H_STOP, H_BIT} smb_hst_e;

   typedef struct packed {
      logic        sda1, sda2, alr1, alr2;  // Pin synchronisers
      smb_hst_e    st;
      logic [4:0]  step;                    // Half period index
      logic [15:0] div;                     // Half period timer
      logic [8:0]  tx, rx;                  // Nine bit shifters
      logic        scl_oe, sda_oe, ack;
      logic [7:0]  crc;                     // Check over bytes since stop
      logic [31:0] rdat;                    // Read data held for APB
   } smb_hst_s;

   smb_hst_s r, n;

   // Next state of the controller
   always_comb begin
      logic       tick, hit;
      logic [8:0] s9;
      tick = (r.div == 16'h0000);
      s9   = {r.rx[7:0], r.sda2};
      hit  = (paddr == HREG_CMD) || (paddr == HREG_STAT);
      n    = r;
      n.sda1 = pins.sda;
      n.sda2 = r.sda1;
      n.alr1 = pins.alert_n;
      n.alr2 = r.alr1;
      if (r.st != H_IDLE) begin
         n.div = tick ? 16'(HALF_CYC - 1) : r.div - 16'h0001;
      end
      unique case (r.st)
         H_IDLE: begin
            // Commands taken at the APB access edge
            if (psel && penable && pwrite && paddr == HREG_CMD) begin
               n.step = 5'h00;
               n.div  = 16'(HALF_CYC - 1);
               n.tx   = {pwdata[CMD_DAT_LSB +: 8], 1'b1};
               if (pwdata[CMD_OP_LSB +: 3] == OP_START) begin
                  n.st = H_START;
               end else if (pwdata[CMD_OP_LSB +: 3] == OP_STOP) begin
                  n.st  = H_STOP;
                  n.crc = 8'h00;
               end else if (pwdata[CMD_OP_LSB +: 3] == OP_WR) begin
                  n.st = H_BIT;
               end else if (pwdata[CMD_OP_LSB +: 3] == OP_RD) begin
                  n.st = H_BIT;
                  n.tx = {8'hFF, pwdata[CMD_NACK]};
               end
            end
         end
         H_START: begin
            // Release data, raise clock, then data low, clock low
            if (tick) begin
               n.step = r.step + 5'h01;
               unique case (r.step[1:0])
                  2'h0: n.sda_oe = 1'b0;
                  2'h1: n.scl_oe = 1'b0;
                  2'h2: n.sda_oe = 1'b1;
                  2'h3: begin
                     n.scl_oe = 1'b1;
                     n.st     = H_IDLE;
                  end
               endcase
            end
         end
         H_STOP: begin
            // Data low, clock high, then data high
            if (tick) begin
               n.step = r.step + 5'h01;
               if (r.step == 5'h00) begin
                  n.sda_oe = 1'b1;
               end else if (r.step == 5'h01) begin
                  n.scl_oe = 1'b0;
               end else begin
                  n.sda_oe = 1'b0;
                  n.st     = H_IDLE;
               end
            end
         end
         H_BIT: begin
            if (tick) begin
               n.step = r.step + 5'h01;
               if (!r.step[0]) begin
                  // Sample previous bit, pull clock low, set next bit
                  if (r.step != 5'h00) begin
                     n.rx = s9;
                  end
                  n.scl_oe = 1'b1;
                  n.sda_oe = ~r.tx[8];
                  n.tx     = {r.tx[7:0], 1'b1};
                  if (r.step == 5'h12) begin
                     // Ninth bit taken: report ack and fold byte
                     n.sda_oe = 1'b0;
                     n.ack    = ~s9[0];
                     n.crc    = smb_crc8(r.crc, s9[8:1]);
                     n.st     = H_IDLE;
                  end
               end else begin
                  n.scl_oe = 1'b0;
               end
            end
         end
      endcase
      // Read data captured in the setup cycle
      if (psel && !penable) begin
         n.rdat = 32'h0000_0000;
         if (paddr == HREG_STAT) begin
            n.rdat[ST_BUSY]          = (r.st != H_IDLE);
            n.rdat[ST_ACK]           = r.ack;
            n.rdat[ST_ALERT]         = ~r.alr2;
            n.rdat[ST_RX_LSB +: 8]   = r.rx[8:1];
            n.rdat[ST_CRC_LSB +: 8]  = r.crc;
         end
      end
      pready  = psel & penable;
      pslverr = psel & penable & ~hit;
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r      <= '0;
         r.sda1 <= 1'b1;
         r.sda2 <= 1'b1;
         r.alr1 <= 1'b1;
         r.alr2 <= 1'b1;
         r.st   <= H_IDLE;
      end else begin
         r <= n;
      end
   end

   assign prdata        = r.rdat;
   assign pins.m_scl_o  = 1'b0;
   assign pins.m_scl_oe = r.scl_oe;
   assign pins.m_sda_o  = 1'b0;
   assign pins.m_sda_oe = r.sda_oe;
endmodule : smb_host

// >>> smb_link_checker.sv
`timescale 1ns/1ps
// Watches the resolved wires and the device data driver
module smb_link_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic scl,
   input wire logic sda,
   input wire logic s_sda_oe
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Device moves data only well inside the low phase
   chk_dev_data_low: assert property ($changed(s_sda_oe) |-> !$past(scl) && !$past(scl, 2))
      else $error("device data moved near a clock high");
   chk_ack_before_rise: assert property ($rose(s_sda_oe) |-> !scl [*2])
      else $error("device pull came too late in the low phase");
   chk_ack_bit_hold: assert property ($rose(s_sda_oe) |-> s_sda_oe [*8])
      else $error("device pull too short");
   chk_release_hold: assert property ($fell(s_sda_oe) |-> !s_sda_oe [*8])
      else $error("device release too short");
   // Clock divider phases, clocking after start, quiet device after stop
   chk_scl_low_width: assert property ($fell(scl) |-> !scl [*6])
      else $error("clock low phase too short");
   chk_scl_high_width: assert property ($rose(scl) |-> scl [*6])
      else $error("clock high phase too short");
   chk_start_clocks: assert property (($fell(sda) && scl) |-> ##[1:40] !scl)
      else $error("no clocking after start");
   chk_stop_quiet: assert property (($rose(sda) && scl) |-> !s_sda_oe [*4])
      else $error("device drives data after stop");
endmodule : smb_link_checker

// >>> smbus_slave_block_access_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("CHECK FAILED %s exp %h got %h", n, (e), (g)); end end
module smbus_slave_block_access_tb_top
   import smb_pkg::*;
();
   localparam logic [7:0] AW = 8'hB0;  // Own address, write
   localparam logic [7:0] AR = 8'hB1;  // Own address, read
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        alert_req = 1'b0;
   logic [31:0] prdata, q, st;        // Bus read data, last read, last status
   logic        pready, pslverr, err, usr_we;
   logic [7:0]  usr_rdata, usr_waddr, usr_wdata, usr_raddr;
   logic [7:0]  pec = 8'h00;           // Running check value
   logic [7:0]  mem [256];             // Register space behind the device
   int          miscompares = 0;
   int          num_checks = 0;
   int          cyc = 0;
   always #2.5 pclk = ~pclk;
   smb_if bus ();
   smb_dev #(.TO_CYC(2000)) u_smb_dev (
      .pclk(pclk), .presetn(presetn), .pins(bus), .alert_req(alert_req),
      .usr_rdata(usr_rdata), .usr_we(usr_we), .usr_waddr(usr_waddr),
      .usr_wdata(usr_wdata), .usr_raddr(usr_raddr));
   smb_host #(.HALF_CYC(8)) u_smb_host (
      .pclk(pclk), .presetn(presetn), .pins(bus), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   smb_link_checker u_smb_link_checker (
      .pclk(pclk), .presetn(presetn), .scl(bus.scl), .sda(bus.sda),
      .s_sda_oe(bus.s_sda_oe));
   // Register space model
   assign usr_rdata = mem[usr_raddr];
   always @(posedge pclk) begin
      if (usr_we === 1'b1) mem[usr_waddr] <= usr_wdata;
   end
   // Hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 60000) begin
         miscompares++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test
   function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] x;
      x = c ^ d;
      for (int i = 0; i < 8; i++) x = {x[6:0], 1'b0} ^ (x[7] ? 8'h07 : 8'h00);
      return x;
   endfunction : crc
   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Controller order, then poll until idle
   task automatic op(input logic [31:0] c);
      apb(1'b1, HREG_CMD, c);
      do apb(1'b0, HREG_STAT, 32'h0); while (q[ST_BUSY] !== 1'b0);
      st = q;
   endtask : op
   task automatic sa();
      op({29'h0, OP_START});
   endtask : sa
   task automatic sp();
      op({29'h0, OP_STOP});
      pec = 8'h00;
   endtask : sp
   task automatic wb(input logic [7:0] d, input logic ea);
      op({16'h0, d, 5'h0, OP_WR});
      `CHK("ack", ea, st[ST_ACK])
      pec = crc(pec, d);
   endtask : wb
   task automatic rb(input logic nk, input logic [7:0] e);
      op({16'h0, 8'h00, 4'h0, nk, OP_RD});
      `CHK("rdata", e, st[ST_RX_LSB +: 8])
      pec = crc(pec, e);
   endtask : rb
   task automatic ptr(input logic [7:0] r);
      sa();
      wb(AW, 1'b1);
      wb(r, 1'b1);
      sp();
   endtask : ptr
   task automatic wreg(input logic [7:0] r, input logic [7:0] d);
      sa();
      wb(AW, 1'b1);
      wb(r, 1'b1);
      wb(d, 1'b1);
      sp();
   endtask : wreg
   task automatic rreg(input logic [7:0] e);
      sa();
      wb(AR, 1'b1);
      rb(1'b1, e);
      sp();
   endtask : rreg
   // Main sequence
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'h00;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, HREG_STAT, 32'h0);
      `CHK("stat", 32'h0, q)
      apb(1'b0, 8'h08, 32'h0);
      `CHK("slverr", 1'b1, err)
      ptr(CFG3_OFS);
      rreg(CFG3_RST);
      wreg(CFG3_OFS, 8'h06);
      ptr(CFG3_OFS);
      rreg(8'h06);
      // Clock held low mid-transfer past the limit: device drops the transfer
      sa();
      wb(AW, 1'b1);
      repeat (2100) @(posedge pclk);
      wb(8'h10, 1'b0);
      sp();
      wreg(8'h10, 8'h5A);
      `CHK("mem", 8'h5A, mem[8'h10])
      ptr(8'h10);
      rreg(8'h5A);
      wreg(CFG0_OFS, 8'h03);
      // Good check byte, then a corrupted one
      for (int k = 0; k < 2; k++) begin
         ptr(8'h20);
         sa();
         wb(AW, 1'b1);
         wb(CMD_BLK_WR, 1'b1);
         for (int i = 0; i < 3; i++) wb(8'hC0 + i[7:0], 1'b1);
         wb(pec ^ k[7:0], k == 0);
         sp();
      end
      `CHK("blk", 8'hC2, mem[8'h22])
      ptr(8'h20);
      sa();
      wb(AW, 1'b1);
      wb(CMD_BLK_RD, 1'b1);
      sa();
      wb(AR, 1'b1);
      rb(1'b0, 8'h03);
      for (int i = 0; i < 3; i++) rb(1'b0, 8'hC0 + i[7:0]);
      rb(1'b1, pec);
      `CHK("crc", 8'h00, st[ST_CRC_LSB +: 8])
      sp();
      // Alert response
      alert_req <= 1'b1;
      // Alert line passes the device flop and the controller synchroniser
      repeat (4) @(posedge pclk);
      apb(1'b0, HREG_STAT, 32'h0);
      `CHK("alert", 1'b1, q[ST_ALERT])
      sa();
      wb({ARA_ADDR, 1'b1}, 1'b1);
      rb(1'b1, AW);
      sp();
      alert_req <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(1'b0, HREG_STAT, 32'h0);
      `CHK("alert", 1'b0, q[ST_ALERT])
      sa();
      wb(8'h66, 1'b0);
      sp();
      finish_test();
   end
endmodule : smbus_slave_block_access_tb_top
